// File: core/ldr_pkg.sv
// Operation
// - 8-bit frame: indicator, command, sixteen data, check
// - 10-bit frame: same order, indicator is IND10 (10'h280)
// - Indicator pattern starts frame, then words counted
// - Command bit 0 enables local dimming
// - Command bit 1 enables backlight scanning
// - Host sends zero in command bits 2-6
// - Command bit 7 selects reversed block orientation
// - Each data word is one block gray
// - Check word is XOR of all prior words
// - Serial clock between 100 and 500 kHz
// - Host keeps five interval limits on the link
package ldr_pkg;

  // ==========================================================
  // Frame layout
  localparam int             NW_MAX     = 10;
  localparam int             NBLK       = 16;
  localparam int             GRAY_BUS_W = NBLK * NW_MAX;
  localparam logic [7:0]     IND8       = 8'haa;
  localparam logic [9:0]     IND10      = 10'h280;
  localparam logic [3:0]     LAST8      = 4'h7;
  localparam logic [3:0]     LAST10     = 4'h9;
  localparam logic [4:0]     SLOT_IND   = 5'h00;
  localparam logic [4:0]     SLOT_CMD   = 5'h01;
  localparam logic [4:0]     SLOT_D0    = 5'h02;
  localparam logic [4:0]     SLOT_CHK   = 5'h12;
  localparam int             CMD_DIM    = 0;
  localparam int             CMD_SCAN   = 1;
  localparam int             CMD_REV    = 7;
  localparam logic [7:0]     RSVD_MASK  = 8'h7c;

  // ==========================================================
  // Timing
  localparam int             CLK_NS        = 8;
  localparam int             SECOND_MAX_NS = 10000;
  localparam int             HALF_NS       = 2000;
  localparam int             FIRST_NS      = 12000;
  localparam int             FOURTH_NS     = 12000;
  localparam int             FIFTH_NS      = 30000;
  localparam int             SECOND_MAX_CYC = SECOND_MAX_NS / CLK_NS;
  localparam int             HALF_CYC      = (HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int             FIRST_CYC     = (FIRST_NS + CLK_NS - 1) / CLK_NS;
  localparam int             FOURTH_CYC    = (FOURTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int             FIFTH_CYC     = (FIFTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int             CYC_W         = 12;

  // ==========================================================
  // States
  typedef enum logic {
    RX_HUNT = 1'b0,
    RX_RECV = 1'b1
  } ldr_rx_state_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_LEAD = 3'b001,
    TX_LOW  = 3'b010,
    TX_HIGH = 3'b011,
    TX_TAIL = 3'b100,
    TX_GAP  = 3'b101
  } ldr_tx_state_t;

endpackage

// File: core/ldr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ldr_if;
  logic sclk;
  logic cs_n;
  logic mosi;

  modport host (
    output sclk,
    output cs_n,
    output mosi
  );

  modport dev (
    input sclk,
    input cs_n,
    input mosi
  );
endinterface
`default_nettype wire

// File: core/ldr_rx.sv
`timescale 1ns/10ps
`default_nettype none
module ldr_rx
  import ldr_pkg::*;
(
  input  wire logic                  mclk_in,
  input  wire logic                  rst_n_in,
  ldr_if.dev                         link,
  input  wire logic                  word_mode_in,
  output logic                       dim_en_out,
  output logic                       scan_en_out,
  output logic                       reverse_out,
  output logic [GRAY_BUS_W-1:0]      gray_out,
  output logic                       frame_ok_out,
  output logic                       frame_err_out,
  output logic                       rsvd_err_out,
  output logic                       busy_out
);

  // ==========================================================
  // Declarations
  ldr_rx_state_t           state_reg;
  logic                    sclk_prev_reg;
  logic                    mode_reg;
  logic [NW_MAX-1:0]       shift_reg;
  logic [3:0]              bit_cnt_reg;
  logic [4:0]              slot_reg;
  logic [NW_MAX-1:0]       acc_reg;
  logic [7:0]              cmd_stage_reg;
  logic [NW_MAX-1:0]       gray_stage_reg [NBLK];
  logic [NW_MAX-1:0]       gray_reg [NBLK];
  logic [CYC_W-1:0]        gap_cnt_reg;
  logic                    dim_reg;
  logic                    scan_reg;
  logic                    rev_reg;
  logic                    ok_reg;
  logic                    err_reg;
  logic                    rsvd_reg;

  logic                    rise;
  logic [NW_MAX-1:0]       word_next;
  logic [NW_MAX-1:0]       word_val;
  logic                    ind_hit;
  logic                    word_done;
  logic                    timeout;
  logic                    abort;
  logic                    chk_done;
  logic                    chk_good;
  logic [3:0]              blk_idx;

  // ==========================================================
  // Link sampling
  assign rise      = link.sclk & ~sclk_prev_reg & ~link.cs_n;
  assign word_next = {shift_reg[NW_MAX-2:0], link.mosi};
  assign word_val  = mode_reg ? word_next : {2'b00, word_next[7:0]};

  always_comb begin
    if (mode_reg) begin
      ind_hit = (word_next == IND10);
    end else begin
      ind_hit = (word_next[7:0] == IND8);
    end
  end

  assign word_done = (state_reg == RX_RECV) && rise &&
                     (bit_cnt_reg == (mode_reg ? LAST10 : LAST8));
  assign timeout   = (state_reg == RX_RECV) && (gap_cnt_reg >= CYC_W'(SECOND_MAX_CYC));
  assign abort     = (state_reg == RX_RECV) && (link.cs_n || timeout);
  assign chk_done  = word_done && (slot_reg == SLOT_CHK);
  assign chk_good  = (word_val == acc_reg);
  assign blk_idx   = 4'(slot_reg - SLOT_D0);

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= link.sclk;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      shift_reg <= '0;
    end else if (link.cs_n) begin
      shift_reg <= '0;
    end else if (rise) begin
      shift_reg <= word_next;
    end
  end

  // ==========================================================
  // Word mode, held steady through a frame
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      mode_reg <= 1'b0;
    end else if (state_reg == RX_HUNT) begin
      mode_reg <= word_mode_in;
    end
  end

  // ==========================================================
  // Frame sequencer
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_reg <= RX_HUNT;
    end else begin
      unique case (state_reg)
        RX_HUNT: begin
          if (rise && ind_hit) begin
            state_reg <= RX_RECV;
          end
        end
        RX_RECV: begin
          if (abort || chk_done) begin
            state_reg <= RX_HUNT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      bit_cnt_reg <= 4'h0;
      slot_reg    <= SLOT_IND;
    end else if (state_reg == RX_HUNT) begin
      bit_cnt_reg <= 4'h0;
      slot_reg    <= SLOT_CMD;
    end else if (word_done) begin
      bit_cnt_reg <= 4'h0;
      slot_reg    <= slot_reg + 5'h01;
    end else if (rise) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // Gap watchdog between serial clock rises
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      gap_cnt_reg <= '0;
    end else if (state_reg == RX_HUNT || rise) begin
      gap_cnt_reg <= '0;
    end else if (!timeout) begin
      gap_cnt_reg <= gap_cnt_reg + CYC_W'(1);
    end
  end

  // ==========================================================
  // Running check and staging
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      acc_reg <= '0;
    end else if (state_reg == RX_HUNT) begin
      acc_reg <= mode_reg ? IND10 : {2'b00, IND8};
    end else if (word_done && slot_reg != SLOT_CHK) begin
      acc_reg <= acc_reg ^ word_val;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cmd_stage_reg <= 8'h00;
    end else if (word_done && slot_reg == SLOT_CMD) begin
      cmd_stage_reg <= word_val[7:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rsvd_reg <= 1'b0;
    end else if (word_done && slot_reg == SLOT_CMD) begin
      rsvd_reg <= |(word_val[7:0] & RSVD_MASK);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NBLK; i++) begin
        gray_stage_reg[i] <= '0;
      end
    end else if (word_done && slot_reg >= SLOT_D0 && slot_reg < SLOT_CHK) begin
      gray_stage_reg[blk_idx] <= word_val;
    end
  end

  // ==========================================================
  // Apply only on a matching check word
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      dim_reg  <= 1'b0;
      scan_reg <= 1'b0;
      rev_reg  <= 1'b0;
    end else if (chk_done && chk_good) begin
      dim_reg  <= cmd_stage_reg[CMD_DIM];
      scan_reg <= cmd_stage_reg[CMD_SCAN];
      rev_reg  <= cmd_stage_reg[CMD_REV];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NBLK; i++) begin
        gray_reg[i] <= '0;
      end
    end else if (chk_done && chk_good) begin
      for (int i = 0; i < NBLK; i++) begin
        gray_reg[i] <= gray_stage_reg[i];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ok_reg  <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      ok_reg  <= chk_done && chk_good;
      err_reg <= (chk_done && !chk_good) || abort;
    end
  end

  // ==========================================================
  // Outputs
  for (genvar g = 0; g < NBLK; g++) begin : g_gray
    assign gray_out[g*NW_MAX +: NW_MAX] = gray_reg[g];
  end

  assign dim_en_out    = dim_reg;
  assign scan_en_out   = scan_reg;
  assign reverse_out   = rev_reg;
  assign frame_ok_out  = ok_reg;
  assign frame_err_out = err_reg;
  assign rsvd_err_out  = rsvd_reg;
  assign busy_out      = (state_reg == RX_RECV);

endmodule
`default_nettype wire

// File: core/ldr_tx.sv
`timescale 1ns/10ps
`default_nettype none
module ldr_tx
  import ldr_pkg::*;
(
  input  wire logic                  mclk_in,
  input  wire logic                  rst_n_in,
  ldr_if.host                        link,
  input  wire logic                  start_in,
  input  wire logic                  word_mode_in,
  input  wire logic                  dim_en_in,
  input  wire logic                  scan_en_in,
  input  wire logic                  reverse_in,
  input  wire logic [GRAY_BUS_W-1:0] gray_in,
  output logic                       busy_out,
  output logic                       done_out
);

  // ==========================================================
  // Declarations
  ldr_tx_state_t           state_reg;
  logic [CYC_W-1:0]        cnt_reg;
  logic                    mode_reg;
  logic [7:0]              cmd_reg;
  logic [GRAY_BUS_W-1:0]   gray_reg;
  logic [4:0]              slot_reg;
  logic [3:0]              bit_reg;
  logic [NW_MAX-1:0]       sh_reg;
  logic                    sclk_reg;
  logic                    cs_n_reg;
  logic                    done_reg;
  logic [NW_MAX-1:0]       chk;
  logic [NW_MAX-1:0]       nxt_word;
  logic [4:0]              nxt_slot;
  logic                    last_bit;

  // ==========================================================
  // Word builder
  always_comb begin
    chk = mode_reg ? IND10 : {2'b00, IND8};
    chk = chk ^ {2'b00, cmd_reg};
    for (int i = 0; i < NBLK; i++) begin
      chk = chk ^ (mode_reg ? gray_reg[i*NW_MAX +: NW_MAX] :
                   {2'b00, gray_reg[i*NW_MAX +: 8]});
    end
  end

  assign nxt_slot = slot_reg + 5'h01;

  always_comb begin
    if (nxt_slot == SLOT_CMD) begin
      nxt_word = {2'b00, cmd_reg};
    end else if (nxt_slot == SLOT_CHK) begin
      nxt_word = chk;
    end else begin
      nxt_word = gray_reg[4'(nxt_slot - SLOT_D0)*NW_MAX +: NW_MAX];
    end
    if (!mode_reg) begin
      nxt_word = {nxt_word[7:0], 2'b00};
    end
  end

  assign last_bit = (bit_reg == (mode_reg ? LAST10 : LAST8));

  // ==========================================================
  // Sequencer
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_reg <= TX_IDLE;
      cnt_reg   <= '0;
      mode_reg  <= 1'b0;
      cmd_reg   <= 8'h00;
      gray_reg  <= '0;
      slot_reg  <= SLOT_IND;
      bit_reg   <= 4'h0;
      sh_reg    <= '0;
      sclk_reg  <= 1'b0;
      cs_n_reg  <= 1'b1;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      cnt_reg  <= cnt_reg + CYC_W'(1);
      unique case (state_reg)
        TX_IDLE: begin
          cnt_reg <= '0;
          if (start_in) begin
            mode_reg  <= word_mode_in;
            cmd_reg   <= {reverse_in, 5'h00, scan_en_in, dim_en_in};
            gray_reg  <= gray_in;
            slot_reg  <= SLOT_IND;
            bit_reg   <= 4'h0;
            sh_reg    <= word_mode_in ? IND10 : {IND8, 2'b00};
            cs_n_reg  <= 1'b0;
            state_reg <= TX_LEAD;
          end
        end
        TX_LEAD: begin
          if (cnt_reg == CYC_W'(FIRST_CYC - 1)) begin
            cnt_reg   <= '0;
            sclk_reg  <= 1'b1;
            state_reg <= TX_HIGH;
          end
        end
        TX_LOW: begin
          if (cnt_reg == CYC_W'(HALF_CYC - 1)) begin
            cnt_reg   <= '0;
            sclk_reg  <= 1'b1;
            state_reg <= TX_HIGH;
          end
        end
        TX_HIGH: begin
          if (cnt_reg == CYC_W'(HALF_CYC - 1)) begin
            cnt_reg  <= '0;
            sclk_reg <= 1'b0;
            if (last_bit && slot_reg == SLOT_CHK) begin
              state_reg <= TX_TAIL;
            end else if (last_bit) begin
              slot_reg  <= nxt_slot;
              bit_reg   <= 4'h0;
              sh_reg    <= nxt_word;
              state_reg <= TX_LOW;
            end else begin
              bit_reg   <= bit_reg + 4'h1;
              sh_reg    <= {sh_reg[NW_MAX-2:0], 1'b0};
              state_reg <= TX_LOW;
            end
          end
        end
        TX_TAIL: begin
          if (cnt_reg == CYC_W'(FOURTH_CYC - HALF_CYC - 1)) begin
            cnt_reg   <= '0;
            cs_n_reg  <= 1'b1;
            state_reg <= TX_GAP;
          end
        end
        TX_GAP: begin
          if (cnt_reg == CYC_W'(FIFTH_CYC - 1)) begin
            done_reg  <= 1'b1;
            state_reg <= TX_IDLE;
          end
        end
        default: begin
          state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs
  assign link.sclk = sclk_reg;
  assign link.cs_n = cs_n_reg;
  assign link.mosi = sh_reg[NW_MAX-1];
  assign busy_out  = (state_reg != TX_IDLE);
  assign done_out  = done_reg;

endmodule
`default_nettype wire

// File: tb/ldr_properties.sv
`timescale 1ns/10ps
`default_nettype none
module ldr_properties
  import ldr_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi
);
  // ==========================================================
  // Link event tracking
  logic        s_d, c_d, first;
  logic [11:0] gap;
  logic [7:0]  nbits;
  logic [3:0]  p8, p10;
  logic [9:0]  sh, acc8, acc10;
  wire logic   rise, fall, cfall, crise;

  assign rise  = sclk & ~s_d;
  assign fall  = ~sclk & s_d;
  assign cfall = ~cs_n & c_d;
  assign crise = cs_n & ~c_d;

  always_ff @(posedge mclk_in) begin
    s_d <= sclk;
    c_d <= cs_n;
  end

  // Cycles since last sclk rise or frame start
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || rise || cfall) begin
      gap <= 12'h001;
    end else if (gap != 12'hfff) begin
      gap <= gap + 12'h001;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      first <= 1'b0;
    end else if (cfall) begin
      first <= 1'b1;
    end else if (rise) begin
      first <= 1'b0;
    end
  end

  // Running XOR of words at both widths
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || cfall) begin
      nbits <= 8'h00;
      p8    <= 4'h0;
      p10   <= 4'h0;
      sh    <= 10'h000;
      acc8  <= 10'h000;
      acc10 <= 10'h000;
    end else if (rise) begin
      nbits <= nbits + 8'h01;
      sh    <= {sh[8:0], mosi};
      p8    <= (p8 == 4'h7) ? 4'h0 : p8 + 4'h1;
      p10   <= (p10 == 4'h9) ? 4'h0 : p10 + 4'h1;
      if (p8 == 4'h7) begin
        acc8 <= acc8 ^ {2'b00, sh[6:0], mosi};
      end
      if (p10 == 4'h9) begin
        acc10 <= acc10 ^ {sh[8:0], mosi};
      end
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("sclk high outside a frame");
  a_mosi_held: assert property (sclk && s_d |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  a_first_gap: assert property (rise && first |-> gap >= 12'd750 && gap <= 12'd3750)
    else $error("select to first clock out of range");
  a_sclk_period: assert property (rise && !first |-> gap >= 12'd250 && gap <= 12'd1250)
    else $error("sclk period out of range");
  a_high_time: assert property (fall |-> gap >= 12'd125 && gap <= 12'd625)
    else $error("sclk high time out of range");
  a_last_gap: assert property (crise |-> gap >= 12'd750 && gap <= 12'd3750)
    else $error("last clock to deselect out of range");
  a_bit_count: assert property (crise |-> nbits == 8'd152 || nbits == 8'd190)
    else $error("frame bit count wrong");
  a_indicator_first: assert property (rise && nbits == 8'd7 |=> sh[7:0] == IND8)
    else $error("frame does not open with indicator");
  a_check_xor: assert property (crise |-> (nbits == 8'd152 && acc8 == 10'h000)
                                || (nbits == 8'd190 && acc10 == 10'h000))
    else $error("check word mismatch on link");
endmodule
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ldr_pkg::*;
  logic                  mclk_in, rst_n_in, start, dim, scan, rev, rx2_mode;
  logic                  busy_tx, done;
  logic [GRAY_BUS_W-1:0] gin, g1, g2, gexp;
  logic [2:0]            c1, c2;
  logic [3:0]            f1, f2;
  logic [9:0]            gb [16];
  int                    fails, num_checks, ok1, er1, ok2, er2, dn;

  ldr_if link_a ();
  ldr_if link_b ();
  ldr_tx ldr_tx_i (.mclk_in, .rst_n_in, .link(link_a.host), .start_in(start),
    .word_mode_in(1'b0), .dim_en_in(dim), .scan_en_in(scan), .reverse_in(rev),
    .gray_in(gin), .busy_out(busy_tx), .done_out(done));
  ldr_rx ldr_rx_i (.mclk_in, .rst_n_in, .link(link_a.dev), .word_mode_in(1'b0),
    .dim_en_out(c1[0]), .scan_en_out(c1[1]), .reverse_out(c1[2]), .gray_out(g1),
    .frame_ok_out(f1[0]), .frame_err_out(f1[1]), .rsvd_err_out(f1[2]), .busy_out(f1[3]));
  ldr_rx ldr_rx_b_i (.mclk_in, .rst_n_in, .link(link_b.dev), .word_mode_in(rx2_mode),
    .dim_en_out(c2[0]), .scan_en_out(c2[1]), .reverse_out(c2[2]), .gray_out(g2),
    .frame_ok_out(f2[0]), .frame_err_out(f2[1]), .rsvd_err_out(f2[2]), .busy_out(f2[3]));
  ldr_properties ldr_properties_i (.mclk_in, .rst_n_in, .sclk(link_a.sclk),
    .cs_n(link_a.cs_n), .mosi(link_a.mosi));

  always #4 mclk_in = ~mclk_in;

  always @(posedge mclk_in) begin
    if (f1[0] === 1'b1) ok1++;
    if (f1[1] === 1'b1) er1++;
    if (f2[0] === 1'b1) ok2++;
    if (f2[1] === 1'b1) er2++;
    if (done === 1'b1) dn++;
  end

  // ==========================================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic check(input logic [335:0] seen, input logic [335:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic shift(input logic [9:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      link_b.mosi = w[i];
      tick(4);
      link_b.sclk = 1'b1;
      tick(4);
      link_b.sclk = 1'b0;
    end
  endtask

  // Host frame on the second link, optionally corrupted or cut short
  task automatic frame(input logic m, input logic [9:0] cmd, input logic bad, input int nw);
    logic [9:0] x;
    int         w;
    w = m ? 10 : 8;
    x = m ? IND10 : {2'b00, IND8};
    rx2_mode = m;
    tick(2);
    link_b.cs_n = 1'b0;
    tick(4);
    if (!m) shift(10'h003, 3);
    shift(x, w);
    check(f2[3], 1'b1);
    x = x ^ cmd;
    shift(cmd, w);
    for (int i = 0; i < nw; i++) begin
      x = x ^ gb[i];
      shift(gb[i], w);
    end
    if (nw == 16) shift(x ^ {9'h000, bad}, w);
    if (nw < 16) begin
      tick(1300);
      check(f2[3], 1'b0);
    end
    tick(4);
    link_b.cs_n = 1'b1;
    link_b.mosi = ~link_b.mosi;
    tick(4);
  endtask

  task automatic expg(input logic m);
    for (int i = 0; i < 16; i++) gexp[i*10 +: 10] = m ? gb[i] : {2'b00, gb[i][7:0]};
  endtask

  // ==========================================================
  // Sequence
  initial begin
    mclk_in = 1'b0;
    rst_n_in = 1'b0;
    start = 1'b0;
    {rev, scan, dim} = 3'b101;
    rx2_mode = 1'b0;
    link_b.sclk = 1'b0;
    link_b.cs_n = 1'b1;
    link_b.mosi = 1'b0;
    for (int i = 0; i < 16; i++) gin[i*10 +: 10] = 10'h300 + 10'(i * 17);
    for (int i = 0; i < 16; i++) gb[i] = 10'h3ff - 10'(i * 33);
    tick(10);
    check({c1, f1, c2, f2, g1, g2, busy_tx, done}, '0);
    rst_n_in = 1'b1;
    frame(1'b1, 10'h003, 1'b0, 16);
    expg(1'b1);
    check({c2, g2, ok2, er2}, {3'b011, gexp, 32'd1, 32'd0});
    frame(1'b1, 10'h080, 1'b1, 16);
    check({c2, g2, ok2, er2}, {3'b011, gexp, 32'd1, 32'd1});
    frame(1'b1, 10'h081, 1'b0, 2);
    check({c2, g2, ok2, er2}, {3'b011, gexp, 32'd1, 32'd2});
    frame(1'b0, 10'h084, 1'b0, 16);
    expg(1'b0);
    check({c2, f2[2], g2, ok2}, {3'b100, 1'b1, gexp, 32'd2});
    start = 1'b1;
    tick(1);
    start = 1'b0;
    check(busy_tx, 1'b1);
    tick(3);
    start = 1'b1;
    dim = 1'b0;
    tick(1);
    start = 1'b0;
    for (int n = 0; n < 90000 && dn == 0; n++) tick(1);
    tick(3);
    for (int i = 0; i < 16; i++) gexp[i*10 +: 10] = 10'(i * 17);
    check({c1, f1[2], f1[3], g1, busy_tx}, {3'b101, 2'b00, gexp, 1'b0});
    check({ok1, er1, dn}, {32'd1, 32'd0, 32'd1});
    complete_run();
  end

  initial begin
    repeat (95000) @(posedge mclk_in);
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
